// ---- include/ocp_defines.vh ----
// Register offsets, field positions and reset values of the compare channel
// Operation
// (RULE_01) Control bit 3 picks timer A or timer B; timer A after reset.
// (RULE_02) Modes 001, 010, 011: match drives pin low, high, or toggles it.
// (RULE_03) Single compare: primary register equals selected count triggers pin action.
// (RULE_04) Timer wrapping before the match leaves the pin unchanged.
// (RULE_05) Mode 100 is single pulse; mode 101 is continuous pulse.
// (RULE_06) Primary match starts the pulse; secondary match ends it.
// (RULE_07) Single pulse mode gives one pulse; rewrite mode 100 for another.
// (RULE_08) Software loads times, period, mode 100, then sets timer run bit 15.
// (RULE_09) Continuous pulse repeats every timer period after the same setup.
// (RULE_10) Modes 110, 111 are PWM; primary becomes read-only latch fed from secondary.
// (RULE_11) Software writes period, duty, PWM mode, then prescale and run bit.
// (RULE_12) Mode 111: fault input low puts the pin in high impedance.
// (RULE_13) Control bit 4 shows a fault has occurred in protected PWM.
// (RULE_14) High impedance holds until fault clears and mode is rewritten.
// (RULE_15) PWM period is (period+1) times 4 oscillator periods times prescale.
// (RULE_16) After count equals period: clear, pin high, latch duty, timer flag.
// (RULE_17) Duty 0x0000 keeps the output low at rollover.
// (RULE_18) Duty above period keeps the output continuously high.
// (RULE_19) PWM drives the pin low when count reaches the active duty.
// (RULE_20) Dual compare: pin high on first match, low on second.
// (RULE_21) Non-PWM compare events set a sticky channel flag until cleared.
// (RULE_22) PWM never sets the channel flag; timer flag signals periods.
`ifndef OCP_DEFINES_VH
`define OCP_DEFINES_VH
`define OCP_ADDR_CTRL 12'h000
`define OCP_ADDR_PRIM 12'h004
`define OCP_ADDR_SEC 12'h008
`define OCP_ADDR_TCON_A 12'h00c
`define OCP_ADDR_TPER_A 12'h010
`define OCP_ADDR_TCNT_A 12'h014
`define OCP_ADDR_TCON_B 12'h018
`define OCP_ADDR_TPER_B 12'h01c
`define OCP_ADDR_TCNT_B 12'h020
`define OCP_ADDR_FLAGS 12'h024
`define OCP_CTRL_MODE_LSB 0
`define OCP_CTRL_TSEL 3
`define OCP_CTRL_FLT 4
`define OCP_TCON_RUN 15
`define OCP_TCON_PS_LSB 4
`define OCP_FLAG_CMP 0
`define OCP_FLAG_TA 1
`define OCP_FLAG_TB 2
`define OCP_MODE_OFF 3'h0
`define OCP_MODE_LOW 3'h1
`define OCP_MODE_HIGH 3'h2
`define OCP_MODE_TOG 3'h3
`define OCP_MODE_SPULSE 3'h4
`define OCP_MODE_CPULSE 3'h5
`define OCP_MODE_PWM 3'h6
`define OCP_MODE_PWMF 3'h7
`define OCP_PERIOD_RST 16'hffff
`define OCP_TICK_DIV 2'h3
`endif

// ---- rtl/ocp_channel.v ----
// Output compare channel with two time bases and an APB register slave
//
// Implementation choices: the placing of the registers and the APB slave port.
`include "ocp_defines.vh"
module ocp_channel (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire fault_sense_input,
  output reg compare_output_pin,
  output reg compare_output_pin_oe,
  output reg compare_irq_flag,
  output reg base_timer_a_irq_flag,
  output reg base_timer_b_irq_flag
);
  reg [2:0] compare_mode_field;
  reg timer_base_select;
  reg fault_status_bit;
  reg [15:0] primary_compare_reg;
  reg [15:0] secondary_compare_reg;
  reg [15:0] timer_control_reg_a;
  reg [15:0] timer_control_reg_b;
  reg [15:0] timer_period_reg_a;
  reg [15:0] timer_period_reg_b;
  reg pin_r;
  reg pulse_done_r;
  reg flt_s1_r;
  reg flt_s2_r;
  reg [1:0] div_r;
  reg mode_wr_r;
  reg [31:0] rd_nxt;
  wire tick;
  wire [15:0] cnt_a;
  wire [15:0] cnt_b;
  wire inc_a;
  wire inc_b;
  wire roll_a;
  wire roll_b;
  wire wr_en;
  wire rd_hit;
  wire [15:0] cnt_sel;
  wire inc_sel;
  wire roll_sel;
  wire per_sel_big;
  wire [15:0] per_sel;
  wire is_pwm;
  wire is_dual;
  wire is_single;
  wire m1;
  wire m2;
  wire fault_now;

  // Instruction clock enable: one in four oscillator-rate cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      div_r <= 2'h0;
    else
      div_r <= (div_r == `OCP_TICK_DIV) ? 2'h0 : div_r + 2'h1;
  end
  assign tick = (div_r == `OCP_TICK_DIV); // [RULE_15]

  assign wr_en = psel & penable & pwrite;
  assign rd_hit = (paddr == `OCP_ADDR_CTRL) | (paddr == `OCP_ADDR_PRIM) |
    (paddr == `OCP_ADDR_SEC) | (paddr == `OCP_ADDR_TCON_A) |
    (paddr == `OCP_ADDR_TPER_A) | (paddr == `OCP_ADDR_TCNT_A) |
    (paddr == `OCP_ADDR_TCON_B) | (paddr == `OCP_ADDR_TPER_B) |
    (paddr == `OCP_ADDR_TCNT_B) | (paddr == `OCP_ADDR_FLAGS);

  // Timer A and timer B
  ocp_timer u_tim_a (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .run(timer_control_reg_a[`OCP_TCON_RUN]),
    .prescale(timer_control_reg_a[`OCP_TCON_PS_LSB+1:`OCP_TCON_PS_LSB]),
    .period(timer_period_reg_a),
    .cnt_wr(wr_en & (paddr == `OCP_ADDR_TCNT_A)),
    .cnt_wdata(pwdata[15:0]),
    .count_r(cnt_a),
    .inc(inc_a),
    .roll(roll_a)
  );
  ocp_timer u_tim_b (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .run(timer_control_reg_b[`OCP_TCON_RUN]),
    .prescale(timer_control_reg_b[`OCP_TCON_PS_LSB+1:`OCP_TCON_PS_LSB]),
    .period(timer_period_reg_b),
    .cnt_wr(wr_en & (paddr == `OCP_ADDR_TCNT_B)),
    .cnt_wdata(pwdata[15:0]),
    .count_r(cnt_b),
    .inc(inc_b),
    .roll(roll_b)
  );

  // Selected time base
  assign cnt_sel = timer_base_select ? cnt_b : cnt_a; // [RULE_01]
  assign inc_sel = timer_base_select ? inc_b : inc_a; // [RULE_01]
  assign roll_sel = timer_base_select ? roll_b : roll_a;
  assign per_sel = timer_base_select ? timer_period_reg_b : timer_period_reg_a;
  assign per_sel_big = secondary_compare_reg > per_sel;

  assign is_pwm = compare_mode_field[2] & compare_mode_field[1]; // [RULE_10]
  assign is_dual = (compare_mode_field == `OCP_MODE_SPULSE) |
    (compare_mode_field == `OCP_MODE_CPULSE); // [RULE_05]
  assign is_single = (compare_mode_field != `OCP_MODE_OFF) & ~compare_mode_field[2];
  // Matches are taken on a count that is held for a timer increment
  assign m1 = inc_sel & (cnt_sel == primary_compare_reg); // [RULE_03] [RULE_06]
  assign m2 = inc_sel & (cnt_sel == secondary_compare_reg); // [RULE_06]
  assign fault_now = (compare_mode_field == `OCP_MODE_PWMF) & ~flt_s2_r; // [RULE_12]

  // Fault pin synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_s1_r <= 1'b1;
      flt_s2_r <= 1'b1;
    end else begin
      flt_s1_r <= fault_sense_input;
      flt_s2_r <= flt_s1_r;
    end
  end

  // Register writes, fault latch and compare flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_mode_field <= `OCP_MODE_OFF;
      timer_base_select <= 1'b0; // [RULE_01]
      fault_status_bit <= 1'b0;
      primary_compare_reg <= 16'h0000;
      secondary_compare_reg <= 16'h0000;
      timer_control_reg_a <= 16'h0000;
      timer_control_reg_b <= 16'h0000;
      timer_period_reg_a <= `OCP_PERIOD_RST;
      timer_period_reg_b <= `OCP_PERIOD_RST;
      compare_irq_flag <= 1'b0;
      base_timer_a_irq_flag <= 1'b0;
      base_timer_b_irq_flag <= 1'b0;
      mode_wr_r <= 1'b0;
    end else begin
      mode_wr_r <= 1'b0;
      if (wr_en) begin
        case (paddr)
          `OCP_ADDR_CTRL: begin
            compare_mode_field <= pwdata[`OCP_CTRL_MODE_LSB+2:`OCP_CTRL_MODE_LSB];
            timer_base_select <= pwdata[`OCP_CTRL_TSEL];
            mode_wr_r <= 1'b1; // [RULE_07] [RULE_14]
          end
          `OCP_ADDR_PRIM: if (!is_pwm) primary_compare_reg <= pwdata[15:0]; // [RULE_10]
          `OCP_ADDR_SEC: secondary_compare_reg <= pwdata[15:0];
          `OCP_ADDR_TCON_A: timer_control_reg_a <= pwdata[15:0] & 16'h8030;
          `OCP_ADDR_TCON_B: timer_control_reg_b <= pwdata[15:0] & 16'h8030;
          `OCP_ADDR_TPER_A: timer_period_reg_a <= pwdata[15:0];
          `OCP_ADDR_TPER_B: timer_period_reg_b <= pwdata[15:0];
          default: ;
        endcase
      end
      // Fault flag: set wins; cleared only by a mode rewrite with the fault gone
      if (fault_now)
        fault_status_bit <= 1'b1; // [RULE_13]
      else if (mode_wr_r)
        fault_status_bit <= 1'b0; // [RULE_14]
      // Duty latched from buffer at rollover
      if (is_pwm & roll_sel)
        primary_compare_reg <= secondary_compare_reg; // [RULE_10] [RULE_16]
      // Sticky flags, write one to clear, set wins
      if (!is_pwm & (((is_single | is_dual) & m1) | (is_dual & m2)))
        compare_irq_flag <= 1'b1; // [RULE_21] [RULE_22]
      else if (wr_en & (paddr == `OCP_ADDR_FLAGS) & pwdata[`OCP_FLAG_CMP])
        compare_irq_flag <= 1'b0; // [RULE_21]
      if (roll_a)
        base_timer_a_irq_flag <= 1'b1; // [RULE_16] [RULE_22]
      else if (wr_en & (paddr == `OCP_ADDR_FLAGS) & pwdata[`OCP_FLAG_TA])
        base_timer_a_irq_flag <= 1'b0;
      if (roll_b)
        base_timer_b_irq_flag <= 1'b1; // [RULE_16] [RULE_22]
      else if (wr_en & (paddr == `OCP_ADDR_FLAGS) & pwdata[`OCP_FLAG_TB])
        base_timer_b_irq_flag <= 1'b0;
    end
  end

  // Output pin state machine per mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r <= 1'b0;
      pulse_done_r <= 1'b0;
    end else begin
      if (mode_wr_r)
        pulse_done_r <= 1'b0; // [RULE_07]
      case (compare_mode_field)
        `OCP_MODE_OFF: pin_r <= 1'b0;
        `OCP_MODE_LOW: if (m1) pin_r <= 1'b0; // [RULE_02] [RULE_04]
        `OCP_MODE_HIGH: if (m1) pin_r <= 1'b1; // [RULE_02]
        `OCP_MODE_TOG: if (m1) pin_r <= ~pin_r; // [RULE_02]
        `OCP_MODE_SPULSE, `OCP_MODE_CPULSE: begin
          if (m2 & pin_r) begin
            pin_r <= 1'b0; // [RULE_20]
            if (compare_mode_field == `OCP_MODE_SPULSE)
              pulse_done_r <= 1'b1; // [RULE_07]
          end else if (m1 & ~pulse_done_r & ~mode_wr_r) begin
            pin_r <= 1'b1; // [RULE_20] [RULE_09]
          end
        end
        default: begin
          if (roll_sel)
            pin_r <= (secondary_compare_reg != 16'h0000); // [RULE_16] [RULE_17]
          else if (m1 & (primary_compare_reg <= per_sel))
            pin_r <= 1'b0; // [RULE_19]
          else if (per_sel_big & (primary_compare_reg > per_sel))
            pin_r <= 1'b1; // [RULE_18]
        end
      endcase
    end
  end

  // Pin drive and enable; fault forces high impedance
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_pin <= 1'b0;
      compare_output_pin_oe <= 1'b0;
    end else begin
      compare_output_pin <= pin_r;
      compare_output_pin_oe <= (compare_mode_field != `OCP_MODE_OFF) &
        ~fault_status_bit & ~fault_now; // [RULE_12] [RULE_14]
    end
  end

  // Read mux
  always @* begin
    rd_nxt = 32'h00000000;
    case (paddr)
      `OCP_ADDR_CTRL: rd_nxt = {27'h0, fault_status_bit, timer_base_select,
        compare_mode_field}; // [RULE_13]
      `OCP_ADDR_PRIM: rd_nxt = {16'h0, primary_compare_reg};
      `OCP_ADDR_SEC: rd_nxt = {16'h0, secondary_compare_reg};
      `OCP_ADDR_TCON_A: rd_nxt = {16'h0, timer_control_reg_a};
      `OCP_ADDR_TPER_A: rd_nxt = {16'h0, timer_period_reg_a};
      `OCP_ADDR_TCNT_A: rd_nxt = {16'h0, cnt_a};
      `OCP_ADDR_TCON_B: rd_nxt = {16'h0, timer_control_reg_b};
      `OCP_ADDR_TPER_B: rd_nxt = {16'h0, timer_period_reg_b};
      `OCP_ADDR_TCNT_B: rd_nxt = {16'h0, cnt_b};
      `OCP_ADDR_FLAGS: rd_nxt = {29'h0, base_timer_b_irq_flag, base_timer_a_irq_flag,
        compare_irq_flag};
      default: rd_nxt = 32'h00000000;
    endcase
  end

  // APB answer: ready in the access cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      if (psel & ~penable & ~pwrite)
        prdata <= rd_nxt;
    end
  end
endmodule

// ---- rtl/ocp_timer.v ----
// One 16-bit time base with run bit, prescaler and period rollover
`include "ocp_defines.vh"
module ocp_timer (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire run,
  input wire [1:0] prescale,
  input wire [15:0] period,
  input wire cnt_wr,
  input wire [15:0] cnt_wdata,
  output reg [15:0] count_r,
  output wire inc,
  output wire roll
);
  reg [7:0] pre_r;
  reg [7:0] pre_max;

  // Prescale ratio 1, 8, 64, 256
  always @* begin
    case (prescale)
      2'h0: pre_max = 8'h00;
      2'h1: pre_max = 8'h07;
      2'h2: pre_max = 8'h3f;
      default: pre_max = 8'hff;
    endcase
  end

  assign inc = run & tick & (pre_r == pre_max); // [RULE_15]
  assign roll = inc & (count_r == period); // [RULE_16]

  // Count up, clear on the increment after a period match
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 8'h00;
      count_r <= 16'h0000;
    end else begin
      if (run & tick)
        pre_r <= (pre_r == pre_max) ? 8'h00 : pre_r + 8'h01;
      if (cnt_wr)
        count_r <= cnt_wdata;
      else if (roll)
        count_r <= 16'h0000; // [RULE_16]
      else if (inc)
        count_r <= count_r + 16'h0001;
    end
  end
endmodule

// ---- tb/ocp_channel_assertions.sv ----
// Port-level assertion checker for the compare channel
module ocp_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire fault_sense_input,
  input wire compare_output_pin_oe,
  input wire compare_irq_flag,
  input wire base_timer_a_irq_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] mode_r;
  logic [2:0] cw_r;
  wire cw = psel && penable && pwrite && pready && paddr == 12'h000;
  wire pwm = mode_r[2] && mode_r[1];
  wire m7 = mode_r == 3'h7;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadow of the mode field and of recent control writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 3'h0;
      cw_r <= 3'h0;
    end else begin
      if (cw)
        mode_r <= pwdata[2:0];
      cw_r <= {cw_r[1:0], cw};
    end
  end
  // Bus answer timing and refusals
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready too long");
  a_err_unmapped: assert property (psel && !penable && paddr > 12'h024 |=> pslverr)
    else $error("no error");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  // Pin and flag behaviour
  a_pwm_no_flag: assert property (
    pwm && $past(pwm) && !compare_irq_flag |=> !compare_irq_flag) else $error("flag in pwm");
  a_fault_hiz: assert property (
    (m7 && !fault_sense_input) [*3] |=> !compare_output_pin_oe) else $error("fault pin driven");
  a_hiz_held: assert property (m7 && !compare_output_pin_oe && !cw && cw_r == 3'h0
    |=> !compare_output_pin_oe) else $error("fault released early");
  a_off_released: assert property (mode_r == 3'h0 && cw_r == 3'h0 |-> !compare_output_pin_oe)
    else $error("pin driven when off");
  c_fault_mode: cover property (cw && pwdata[2:0] == 3'h7);
  c_pwm_period: cover property (pwm && base_timer_a_irq_flag);
  c_fault_hiz: cover property (m7 && !compare_output_pin_oe);
endmodule
bind ocp_channel ocp_chk u_ocp_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .fault_sense_input, .compare_output_pin_oe, .compare_irq_flag,
  .base_timer_a_irq_flag);

// ---- tb/ocp_load_model.sv ----
// Load on the compare pin and source of the fault sense line
module ocp_load_model (
  input wire logic pin,
  input wire logic oe,
  input wire logic trip,
  output logic pad,
  output logic fault_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-down takes the pad low once the pin is released
  assign pad = oe ? pin : 1'b0;
  // Fault line pulled low while tripped
  assign fault_n = !trip;
endmodule

// ---- tb/tb_top.sv ----
// Register-level bench for the compare channel
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, trip, pready, pslverr, pin, oe, cflag, ta, tbf;
  logic pad, fault_n, p;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_mismatch, cmp_count, hi;
  int dt[3] = '{0, 3, 12};
  int lo[3] = '{0, 36, 120};
  int hh[3] = '{0, 48, 120};
  ocp_channel u_ocp_channel (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fault_sense_input(fault_n), .compare_output_pin(pin),
    .compare_output_pin_oe(oe), .compare_irq_flag(cflag), .base_timer_a_irq_flag(ta),
    .base_timer_b_irq_flag(tbf));
  ocp_load_model u_ocp_load_model (.pin, .oe, .trip, .pad, .fault_n);
  // Free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic close_out;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One bus transfer, held until ready is seen
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i == 20) begin
      n_mismatch++;
      close_out();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Clear flags, wait for the next compare event
  task automatic wait_flag;
    int i;
    xfer(1, 12'h024, 7);
    for (i = 0; i < 300 && cflag !== 1'b1; i++)
      @(posedge pclk);
    if (i == 300) begin
      n_mismatch++;
      close_out();
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic meas(input int n);
    hi = 0;
    repeat (n) begin
      @(posedge pclk);
      hi += (pin === 1'b1);
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, trip} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    begin : main
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(0, 12'h000, 0);
      chk("ctrl", 0, rd);
      xfer(0, 12'h010, 0);
      chk("period", 32'hffff, rd);
      xfer(0, 12'h028, 0);
      chk("unmapped", 0, rd);
      // Single compare on timer A: high, toggle, low, out of reach
      xfer(1, 12'h010, 32'h14);
      xfer(1, 12'h004, 5);
      xfer(1, 12'h000, 2);
      xfer(1, 12'h00c, 32'h8000);
      wait_flag();
      chk("drive high", 1, pin);
      xfer(1, 12'h000, 3);
      wait_flag();
      p = pin;
      wait_flag();
      chk("toggle", !p, pin);
      xfer(1, 12'h000, 1);
      wait_flag();
      chk("drive low", 0, pin);
      xfer(1, 12'h004, 32'h1e);
      xfer(1, 12'h000, 2);
      xfer(1, 12'h024, 7);
      repeat (200) @(posedge pclk);
      chk("no match", 0, {cflag, pin});
      // Timer B as time base
      xfer(1, 12'h00c, 0);
      xfer(1, 12'h004, 5);
      xfer(1, 12'h01c, 32'h14);
      xfer(1, 12'h000, 32'ha);
      xfer(1, 12'h018, 32'h8000);
      wait_flag();
      chk("timer b", 1, pin);
      xfer(1, 12'h000, 32'h9);
      wait_flag();
      // Dual compare pulses on timer A
      xfer(1, 12'h014, 0);
      xfer(1, 12'h008, 8);
      xfer(1, 12'h004, 4);
      xfer(1, 12'h000, 4);
      xfer(1, 12'h00c, 32'h8000);
      meas(252);
      chk("one pulse", 16, hi);
      meas(252);
      chk("no repeat", 0, hi);
      xfer(1, 12'h000, 4);
      meas(252);
      chk("rearm", 16, hi);
      xfer(1, 12'h000, 5);
      repeat (84) @(posedge pclk);
      meas(252);
      chk("continuous", 48, hi);
      // PWM with duty zero, mid and above period
      xfer(1, 12'h00c, 0);
      xfer(1, 12'h014, 0);
      xfer(1, 12'h010, 9);
      xfer(1, 12'h008, 3);
      xfer(1, 12'h000, 6);
      xfer(1, 12'h00c, 32'h8000);
      xfer(1, 12'h024, 7);
      foreach (dt[k]) begin
        xfer(1, 12'h008, dt[k]);
        repeat (80) @(posedge pclk);
        meas(120);
        chk("pwm high", 1, hi >= lo[k] && hi <= hh[k]);
      end
      xfer(1, 12'h004, 32'h55);
      xfer(0, 12'h004, 0);
      chk("duty latch", 12, rd);
      chk("pwm flags", 1, {cflag, ta});
      chk("timer b flag", 1, tbf);
      // Fault shutdown and re-enable
      xfer(1, 12'h008, 3);
      xfer(1, 12'h000, 7);
      trip <= 1'b1;
      repeat (10) @(posedge pclk);
      xfer(0, 12'h000, 0);
      chk("fault hiz", 2, {rd[4], oe});
      // Mode rewrite alone, fault still present: pin stays released
      xfer(1, 12'h000, 7);
      repeat (5) @(posedge pclk);
      chk("still tripped", 0, {oe, pad});
      trip <= 1'b0;
      repeat (20) @(posedge pclk);
      chk("held", 0, oe);
      xfer(1, 12'h000, 7);
      repeat (5) @(posedge pclk);
      chk("released", 1, oe);
    end
    close_out();
  end
endmodule
